// File: hdl/fbc_pkg.sv
// shared constants and types for the switch and balancing control block
package fbc_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses on the apb bus)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_SWITCH_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CELL_BAL = 8'h04;

	// switch_control_status field positions
	localparam int BIT_PRE_DIS = 0;
	localparam int BIT_CHG_EN = 1;
	localparam int BIT_DIS_EN = 2;
	localparam int BIT_HOLDOFF = 3;
	localparam int BIT_PWM_PRE = 4;
	localparam int BIT_PWM_CHG = 5;
	localparam int BIT_BUSY = 7;

	// reset values: precharge enabled, charge and discharge off
	localparam logic [5:0] RST_SWITCH_CTRL = 6'h00;
	localparam logic [3:0] RST_CELL_BAL = 4'h0;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int HOLDOFF_MS = 1000;
	localparam int HOLDOFF_CYC = HOLDOFF_MS * (CLK_HZ / 1000);
	localparam int HOLD_W = 24;
	localparam logic [1:0] SYNC_SLOW_TICKS = 2'h3;
	localparam logic [1:0] SYNC_FAST_CYCLES = 2'h3;

	// crossing engine states
	typedef enum logic [1:0] {SYNC_IDLE, SYNC_SLOW, SYNC_FAST} fbc_sync_state_t;

endpackage : fbc_pkg

// File: hdl/fbc_sync_if.sv
// handshake between the register side and the crossing engine
interface fbc_sync_if;
	logic start;
	logic done;
	logic busy;
	logic slowPin;

	modport host (output start, output slowPin, input done, input busy);
	modport engine (input start, input slowPin, output done, output busy);
endinterface : fbc_sync_if

// File: hdl/fbc_sync_engine.sv
// guard timer for moving a written value into the slow oscillator domain
module fbc_sync_engine (
	input wire logic sys_clk, // processor clock
	input wire logic reset, // async reset, active high
	fbc_sync_if.engine sif // start, done and busy handshake
);

	// ------------------------------------------------------------
	// slow oscillator pin synchroniser and edge detect
	// ------------------------------------------------------------
	logic slowMeta_r;
	logic slowSync_r;
	logic slowPrev_r;
	logic slowTick;
	fbc_pkg::fbc_sync_state_t state_r;
	fbc_pkg::fbc_sync_state_t state_nxt;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;

	// the edge detector reads the second and third stages, never the first
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			slowMeta_r <= 1'b0;
			slowSync_r <= 1'b0;
			slowPrev_r <= 1'b0;
		end
		else
		begin
			slowMeta_r <= sif.slowPin;
			slowSync_r <= slowMeta_r;
			slowPrev_r <= slowSync_r;
		end
	end

	assign slowTick = slowSync_r & ~slowPrev_r;

	// ------------------------------------------------------------
	// three slow edges, then three processor cycles
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			fbc_pkg::SYNC_IDLE:
			begin
				cnt_nxt = 2'h0;
				if (sif.start)
					state_nxt = fbc_pkg::SYNC_SLOW;
			end
			fbc_pkg::SYNC_SLOW:
			begin
				if (slowTick)
				begin
					cnt_nxt = cnt_r + 2'h1;
					if (cnt_r == fbc_pkg::SYNC_SLOW_TICKS - 2'h1)
					begin
						cnt_nxt = 2'h0;
						state_nxt = fbc_pkg::SYNC_FAST;
					end
				end
			end
			fbc_pkg::SYNC_FAST:
			begin
				cnt_nxt = cnt_r + 2'h1;
				if (cnt_r == fbc_pkg::SYNC_FAST_CYCLES - 2'h1)
				begin
					cnt_nxt = 2'h0;
					state_nxt = fbc_pkg::SYNC_IDLE;
				end
			end
			default:
			begin
				cnt_nxt = 2'h0;
				state_nxt = fbc_pkg::SYNC_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			state_r <= fbc_pkg::SYNC_IDLE;
			cnt_r <= 2'h0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// done marks the last guard cycle; busy falls on the next edge
	assign sif.busy = (state_r != fbc_pkg::SYNC_IDLE);
	assign sif.done = (state_r == fbc_pkg::SYNC_FAST) &&
		(cnt_r == fbc_pkg::SYNC_FAST_CYCLES - 2'h1);

endmodule : fbc_sync_engine

// File: hdl/fbc_top.sv
// switch driver enables and cell balancing control behind an apb slave

// Summary of operation
// - software can turn switches on and off; hold-off blocks only the direct charge and discharge enables.
// - pwm from the capture unit reaches gates without any pin setup.
// - precharge switch is enabled out of reset.
// - power-off mode drives every switch output disabled.
// - waking from power-off leaves charge, discharge off and precharge on.
// - after a trip, a one second hold-off blocks direct charge and discharge re-enable.
// - bit 7 reads one while a written value is still crossing.
// - writes during a crossing are dropped, for both registers.
// - bit 5 routes pwm and not-trip onto the charge gate.
// - bit 4 routes pwm and not-trip onto the precharge gate.
// - bit 3 reads one while the hold-off timer runs.
// - bit 2 clear forces discharge off; a trip clears it.
// - bit 1 clear forces charge off unless bit 5 is set; a trip clears it.
// - bit 0 set disables precharge unless bit 4 is set; a trip clears it.
// - balancing bits 3 to 0 enable cells four to one.
// - two neighbouring balancing requests turn both switches off.
// - power-off mode holds all balancing switches off.
// - balancing bits 7 to 4 ignore writes and read zero.
module fbc_top #(
	parameter int unsigned HoldoffCycles = fbc_pkg::HOLDOFF_CYC
) (
	input wire logic sys_clk, // processor clock, 10 MHz
	input wire logic reset, // async reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic pwmIn, // pwm from the capture unit
	input wire logic powerOff, // device in power-off mode
	input wire logic protTrip, // current protection trip pin
	input wire logic protChgOff, // protection holds charge off unless bit 5 is set
	input wire logic protDisOff, // protection holds discharge off
	input wire logic slowOscPin, // slow rc oscillator clock pin
	output logic chargeGate, // charge switch enable
	output logic dischargeGate, // discharge switch enable
	output logic prechargeGate, // precharge switch enable
	output logic [3:0] balanceEn // balancing switch enables
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	fbc_sync_if sif ();

	logic [2:0] pinMeta_r;
	logic [2:0] pinSync_r;
	logic tripS;
	logic chgOffS;
	logic disOffS;

	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic hitSw;
	logic hitCb;
	logic apbAccess;
	logic wrReq;
	logic rdReq;
	logic wrAcc;
	logic [31:0] rdMux;

	logic [5:0] pend_r;
	logic pendSel_r;
	logic applyCtrl;
	logic applyBal;

	logic [5:0] ctrl_r;
	logic [5:0] ctrl_nxt;
	logic [5:0] ctrlApplied;
	logic [3:0] cbal_r;
	logic [3:0] cbal_nxt;

	logic [fbc_pkg::HOLD_W-1:0] hold_r;
	logic [fbc_pkg::HOLD_W-1:0] hold_nxt;
	logic holdoffRun;

	logic chg_nxt;
	logic dis_nxt;
	logic pre_nxt;
	logic [3:0] bal_nxt;
	logic [5:0] reqPad;
	logic chgGate_r;
	logic disGate_r;
	logic preGate_r;
	logic [3:0] bal_r;

	// address match, shared by the read mux and the write path
	function automatic logic isReg(input logic [7:0] a, input logic [7:0] off);
		isReg = (a == off);
	endfunction : isReg

	// ------------------------------------------------------------
	// protection pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pinMeta_r <= 3'h0;
			pinSync_r <= 3'h0;
		end
		else
		begin
			pinMeta_r <= {protDisOff, protChgOff, protTrip};
			pinSync_r <= pinMeta_r;
		end
	end

	assign tripS = pinSync_r[0];
	assign chgOffS = pinSync_r[1];
	assign disOffS = pinSync_r[2];

	// ------------------------------------------------------------
	// apb slave: one wait state so read data comes from a flop
	// ------------------------------------------------------------
	assign hitSw = isReg(paddr, fbc_pkg::ADDR_SWITCH_CTRL);
	assign hitCb = isReg(paddr, fbc_pkg::ADDR_CELL_BAL);
	assign apbAccess = psel & penable;
	assign wrReq = apbAccess & pready_r & pwrite;
	assign rdReq = apbAccess & ~pready_r & ~pwrite;
	assign wrAcc = wrReq & ~sif.busy & (hitSw | hitCb);

	assign rdMux = hitSw ? {24'h0, sif.busy, 1'b0, ctrl_r[5:4], holdoffRun,
		ctrl_r[2:0]} : (hitCb ? {28'h0, cbal_r} : 32'h0);

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end
		else
		begin
			pready_r <= apbAccess & ~pready_r;
			pslverr_r <= apbAccess & ~pready_r & ~(hitSw | hitCb);
			if (rdReq)
				prdata_r <= rdMux;
		end
	end

	// ------------------------------------------------------------
	// crossing engine: an accepted write waits here until applied
	// ------------------------------------------------------------
	assign sif.start = wrAcc;
	assign sif.slowPin = slowOscPin;

	fbc_sync_engine uSync (
		.sys_clk(sys_clk),
		.reset(reset),
		.sif(sif)
	);

	// one pending slot serves both registers, so one busy covers all
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pend_r <= 6'h00;
			pendSel_r <= 1'b0;
		end
		else if (wrAcc)
		begin
			pend_r <= pwdata[5:0];
			pendSel_r <= hitCb;
		end
	end

	assign applyCtrl = sif.done & ~pendSel_r;
	assign applyBal = sif.done & pendSel_r;

	// ------------------------------------------------------------
	// switch control bits
	// ------------------------------------------------------------
	// enables written during hold-off land as zero
	assign ctrlApplied = applyCtrl ? {pend_r[5:4], 1'b0,
		pend_r[2:1] & {2{~holdoffRun}}, pend_r[0]} : ctrl_r;
	// trip or power-off clears bits 2 to 0
	assign ctrl_nxt = (tripS | powerOff) ? {ctrlApplied[5:3], 3'b000}
		: ctrlApplied;
	// only the low nibble is stored
	assign cbal_nxt = applyBal ? pend_r[3:0] : cbal_r;

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			ctrl_r <= fbc_pkg::RST_SWITCH_CTRL;
			cbal_r <= fbc_pkg::RST_CELL_BAL;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			cbal_r <= cbal_nxt;
		end
	end

	// ------------------------------------------------------------
	// hold-off timer, reloaded while the trip stays high
	// ------------------------------------------------------------
	// count runs out one second after the trip releases
	assign hold_nxt = tripS ? fbc_pkg::HOLD_W'(HoldoffCycles)
		: (holdoffRun ? hold_r - 1'b1 : hold_r);
	assign holdoffRun = (hold_r != '0);

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			hold_r <= '0;
		else
			hold_r <= hold_nxt;
	end

	// ------------------------------------------------------------
	// gate outputs
	// ------------------------------------------------------------
	// charge gate, pwm path needs no pin setup
	assign chg_nxt = ~powerOff & (ctrl_r[fbc_pkg::BIT_PWM_CHG] ?
		(pwmIn & ~tripS) :
		(ctrl_r[fbc_pkg::BIT_CHG_EN] & ~tripS & ~chgOffS & ~holdoffRun));
	// discharge only with the bit set and protection quiet
	assign dis_nxt = ~powerOff & ctrl_r[fbc_pkg::BIT_DIS_EN] & ~tripS &
		~disOffS & ~holdoffRun;
	assign pre_nxt = ~powerOff & (ctrl_r[fbc_pkg::BIT_PWM_PRE] ?
		(pwmIn & ~tripS) : (~ctrl_r[fbc_pkg::BIT_PRE_DIS] & ~tripS));

	// each cell drops out if a neighbour is also requested
	assign reqPad = {1'b0, cbal_r, 1'b0};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : gBal
			assign bal_nxt[gi] = ~powerOff & reqPad[gi+1] & ~reqPad[gi] &
				~reqPad[gi+2];
		end
	endgenerate

	// outputs register the gated values, low during reset
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			chgGate_r <= 1'b0;
			disGate_r <= 1'b0;
			preGate_r <= 1'b0;
			bal_r <= 4'h0;
		end
		else
		begin
			chgGate_r <= chg_nxt;
			disGate_r <= dis_nxt;
			preGate_r <= pre_nxt;
			bal_r <= bal_nxt;
		end
	end

	assign chargeGate = chgGate_r;
	assign dischargeGate = disGate_r;
	assign prechargeGate = preGate_r;
	assign balanceEn = bal_r;
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence seqAccept;
		wrAcc;
	endsequence

	sequence seqGuard;
		sif.busy [*6];
	endsequence

	// busy shows for the first six cycles after an accepted write
	a_busy_guard_held: assert property (
		@(posedge sys_clk) disable iff (reset) seqAccept |=> seqGuard)
		else $error("busy flag dropped during crossing guard");

	a_busy_write_dropped: assert property (
		@(posedge sys_clk) disable iff (reset)
		(wrReq && sif.busy && !sif.done && !tripS && !powerOff)
		|=> (ctrl_r == $past(ctrl_r)) && (cbal_r == $past(cbal_r)))
		else $error("write accepted while crossing busy");

	// trip clears the three enable bits
	a_trip_clears_bits: assert property (
		@(posedge sys_clk) disable iff (reset) tripS |=> ctrl_r[2:0] == 3'h0)
		else $error("trip did not clear switch bits");

	// no direct enable while hold-off runs
	a_holdoff_blocks: assert property (
		@(posedge sys_clk) disable iff (reset)
		(holdoffRun && !ctrl_r[fbc_pkg::BIT_PWM_CHG])
		|=> !chgGate_r && !disGate_r)
		else $error("switch enabled during hold-off");

	a_pwroff_gates: assert property (
		@(posedge sys_clk) disable iff (reset)
		powerOff |=> !chgGate_r && !disGate_r && !preGate_r)
		else $error("switch on in power-off mode");

	a_pwroff_balance: assert property (
		@(posedge sys_clk) disable iff (reset) powerOff |=> bal_r == 4'h0)
		else $error("balancing on in power-off mode");

	a_bal_adjacent: assert property (
		@(posedge sys_clk) disable iff (reset)
		(bal_r & {1'b0, bal_r[3:1]}) == 4'h0)
		else $error("adjacent balancing switches on");

	// pwm routing onto the charge gate
	a_pwm_charge: assert property (
		@(posedge sys_clk) disable iff (reset)
		(ctrl_r[fbc_pkg::BIT_PWM_CHG] && !powerOff)
		|=> chgGate_r == $past(pwmIn && !tripS))
		else $error("charge gate does not follow pwm");

	// pwm routing onto the precharge gate
	a_pwm_precharge: assert property (
		@(posedge sys_clk) disable iff (reset)
		(ctrl_r[fbc_pkg::BIT_PWM_PRE] && !powerOff)
		|=> preGate_r == $past(pwmIn && !tripS))
		else $error("precharge gate does not follow pwm");

	a_bal_upper_zero: assert property (
		@(posedge sys_clk) disable iff (reset)
		(rdReq && hitCb) |=> prdata_r[31:4] == 28'h0)
		else $error("balancing upper bits not zero");

endmodule : fbc_top

// File: sim/fbc_switch_model.sv
// behavioural model of the external power switches and their sense line
module fbc_switch_model (
	input wire logic sys_clk, // processor clock
	input wire logic surge, // commanded overcurrent on the pack
	input wire logic chargeGate, // charge switch enable
	input wire logic dischargeGate, // discharge switch enable
	input wire logic prechargeGate, // precharge switch enable
	output logic protTrip // current protection trip
);
	timeunit 1ns;
	timeprecision 1ps;

	initial protTrip = 1'b0;

	// a surge only trips while some path conducts, so opening every
	// switch ends the trip by itself, as on a real pack
	always @(posedge sys_clk)
		protTrip <= surge & (chargeGate | dischargeGate | prechargeGate);
endmodule : fbc_switch_model

// File: sim/tb_fbc_top.sv
// self-checking bench for the switch and balancing control block
module tb_fbc_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned Hold = 200;
	localparam logic [7:0] ACTL = fbc_pkg::ADDR_SWITCH_CTRL;
	localparam logic [7:0] ABAL = fbc_pkg::ADDR_CELL_BAL;
	typedef struct {string n; logic [32:0] e; logic [32:0] m;} fbc_note_t;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pwmIn = 1'b0;
	logic powerOff = 1'b0;
	logic protTrip;
	logic protChgOff = 1'b0;
	logic protDisOff = 1'b0;
	logic slowOscPin = 1'b0;
	logic chargeGate;
	logic dischargeGate;
	logic prechargeGate;
	logic [3:0] balanceEn;
	logic surge = 1'b0;
	logic probe = 1'b0;
	logic [2:0] slowCnt = 3'h0;
	logic [5:0] ctl;
	logic [31:0] rq;
	logic [32:0] seen;
	fbc_note_t nq[$];
	fbc_note_t cur;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;

	fbc_top #(.HoldoffCycles(Hold)) u_fbc_top (.sys_clk(sys_clk),
		.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwmIn(pwmIn), .powerOff(powerOff),
		.protTrip(protTrip), .protChgOff(protChgOff),
		.protDisOff(protDisOff), .slowOscPin(slowOscPin),
		.chargeGate(chargeGate), .dischargeGate(dischargeGate),
		.prechargeGate(prechargeGate), .balanceEn(balanceEn));

	fbc_switch_model u_fbc_switch_model (.sys_clk(sys_clk), .surge(surge),
		.chargeGate(chargeGate), .dischargeGate(dischargeGate),
		.prechargeGate(prechargeGate), .protTrip(protTrip));

	always #50 sys_clk = ~sys_clk;

	// slow oscillator pin, eight processor cycles a period
	always @(posedge sys_clk)
	begin
		slowCnt <= slowCnt + 3'h1;
		slowOscPin <= slowCnt[2];
	end

	// ------------------------------------------------------------
	// checking
	// ------------------------------------------------------------
	task automatic complete_run();
		// notes never answered mean a transfer or probe went missing
		bad_count += nq.size();
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	task automatic check(input string n, input logic [32:0] s, e, m);
		comparisons++;
		if ((s & m) !== (e & m))
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e & m, s & m);
		end
	endtask : check

	// every finished transfer or probe consumes the oldest note
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			complete_run();
		end
		if ((psel & penable & pready) === 1'b1 || probe)
		begin
			seen = {pslverr, pwrite ? 32'h0 : prdata};
			if (probe)
				seen = {26'h0, balanceEn, chargeGate, dischargeGate, prechargeGate};
			if (nq.size() == 0)
			begin
				bad_count++;
				$display("MISMATCH unexpected result expected none seen %h", seen);
			end
			else
			begin
				cur = nq.pop_front();
				if (cur.m !== 33'h0)
					check(cur.n, seen, cur.e, cur.m);
			end
		end
	end

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	task automatic nt(input string n, input logic [32:0] e, m);
		nq.push_back('{n, e, m});
	endtask : nt

	// holds the request until pready is seen high, then releases it
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge sys_clk);
			n++;
		end
		// a slave that never answers counts against the run
		if (pready !== 1'b1)
			bad_count++;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : bus

	function automatic logic unm(logic [7:0] a);
		return a !== ACTL && a !== ABAL;
	endfunction : unm

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		nt("pslverr", {unm(a), 32'h0}, {1'b1, 32'h0});
		bus(1'b1, a, d, rq);
	endtask : wr

	task automatic rd(input string n, input logic [7:0] a,
		input logic [31:0] e, m);
		nt(n, {unm(a), e}, {1'b1, m});
		bus(1'b0, a, 32'h0, rq);
	endtask : rd

	// guard wait: poll until the crossing has finished, bounded
	task automatic idle();
		int n;
		n = 0;
		rq = 32'h80;
		while (rq[7] !== 1'b0 && n < 100)
		begin
			nt("poll", 33'h0, 33'h0);
			bus(1'b0, ACTL, 32'h0, rq);
			n++;
		end
		// a busy flag that never clears counts against the run
		if (rq[7] !== 1'b0)
			bad_count++;
	endtask : idle

	task automatic pg(input string n, input logic [3:0] b, input logic [2:0] g);
		nt(n, {26'h0, b, g}, 33'h7F);
		probe <= 1'b1;
		@(posedge sys_clk);
		probe <= 1'b0;
		@(posedge sys_clk);
	endtask : pg

	// expected gates without trip, hold-off or power-off
	function automatic logic [2:0] gx(logic [5:0] c, logic pw, co, dof);
		return {c[5] ? pw : c[1] & !co, c[2] & !dof, c[4] ? pw : !c[0]};
	endfunction : gx

	function automatic logic [3:0] bal(logic [3:0] r);
		return r & ~{1'b0, r[3:1]} & ~{r[2:0], 1'b0};
	endfunction : bal

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(49451));
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		pg("reset gates", 4'h0, 3'h1);
		rd("reset ctl", ACTL, 32'h0, 32'hFFFFFFFF);
		rd("reset bal", ABAL, 32'h0, 32'hFFFFFFFF);
		wr(8'h08, $urandom());
		rd("unmapped", 8'h08, 32'h0, 32'hFFFFFFFF);
		wr(ACTL, 32'hFFFFFFFF);
		rd("busy", ACTL, 32'h80, 32'h80);
		wr(ABAL, 32'h5);
		idle();
		rd("ctl ro", ACTL, 32'h37, 32'hFFFFFFFF);
		rd("bal dropped", ABAL, 32'h0, 32'hFFFFFFFF);
		for (int i = 0; i < 8; i++)
		begin
			ctl = {i[1], i[0], 1'b0, 3'($urandom())};
			wr(ACTL, {26'h0, ctl});
			idle();
			for (int p = 0; p < 2; p++)
			begin
				pwmIn <= p[0];
				protChgOff <= 1'($urandom());
				protDisOff <= 1'($urandom());
				repeat (5) @(posedge sys_clk);
				pg("gates", 4'h0, gx(ctl, pwmIn, protChgOff, protDisOff));
			end
		end
		protChgOff <= 1'b0;
		protDisOff <= 1'b0;
		// charge and discharge enabled together, precharge left on
		wr(ACTL, 32'h06);
		idle();
		for (int v = 0; v < 16; v++)
		begin
			wr(ABAL, {24'h0, 4'($urandom()), v[3:0]});
			idle();
			rd("bal", ABAL, {28'h0, v[3:0]}, 32'hFFFFFFFF);
			pg("bal", bal(v[3:0]), 3'h7);
		end
		wr(ABAL, 32'h5);
		idle();
		powerOff <= 1'b1;
		repeat (3) @(posedge sys_clk);
		pg("off", 4'h0, 3'h0);
		powerOff <= 1'b0;
		repeat (3) @(posedge sys_clk);
		pg("wake", 4'h5, 3'h1);
		rd("wake ctl", ACTL, 32'h0, 32'h07);
		wr(ACTL, 32'h06);
		idle();
		surge <= 1'b1;
		repeat (2) @(posedge sys_clk);
		surge <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rd("trip ctl", ACTL, 32'h08, 32'hFFFFFFFF);
		pg("holdoff", 4'h5, 3'h1);
		wr(ACTL, 32'h06);
		idle();
		rd("holdoff ctl", ACTL, 32'h08, 32'hFFFFFFFF);
		repeat (Hold + 20) @(posedge sys_clk);
		rd("expired", ACTL, 32'h0, 32'hFFFFFFFF);
		wr(ACTL, 32'h06);
		idle();
		pg("reenable", 4'h5, 3'h7);
		complete_run();
	end
endmodule : tb_fbc_top
